/* File: crc_current_ref.sv */
`default_nettype none
// How it works
// R1 - The current output is on whenever the step count is nonzero and off when it is zero.
// R2 - Control bit 7 picks direction, 0 sources and 1 sinks current.
// R3 - Control bit 6 picks the step size, 0 unit steps and 1 eight times larger steps.
// R4 - Control bits 5 to 0 are the step count, output being direction times step times count.
// R5 - Fine-trim mode lets a chosen counter-array waveform gate an extra two-LSB cell.
// R6 - With low count bits 00b, a full duty trim waveform equals low bits 10b.
// R7 - Configuration bit 7 turns fine-trim mode on or off.
// R8 - The source select picks counter-array channel 0 to 3 by 000 to 011, 4 by 100, 5 by 101.
// R9 - Software writes no reserved source select code.
// R10 - Configuration bits 6 to 3 read as zero and ignore writes.
// R11 - Both registers sit at address 0xB9, control on page 0x0 and configuration on page 0xF.
// R12 - Reset clears every field of both registers.
module crc_current_ref
  import crc_pkg::*;
#(
  parameter int CHANNELS = CRC_CHANNELS
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire crc_sfr_s i_sfr,
  input wire logic [CHANNELS-1:0] i_counter_array_output,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output crc_drive_s o_drive,
  output logic [9:0] o_level_ua
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rdata_d;
  logic rvalid_d;

  // Decodes one page at the shared address.
  function automatic logic hit(input crc_sfr_s s, input logic [3:0] pg);
    hit = (s.addr == CRC_SFR_ADDR) && (s.page == pg);
  endfunction

  // Computes register next values and read data.
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    rvalid_d = 1'b0;
    // R11 paged decode
    if (i_sfr.wr && hit(i_sfr, CRC_PAGE_CTRL)) begin
      ctrl_d = i_sfr.wdata;
    end
    // R10 unused bits dropped
    if (i_sfr.wr && hit(i_sfr, CRC_PAGE_CFG)) begin
      cfg_d = i_sfr.wdata & CRC_CFG_RD_MASK;
    end
    if (i_sfr.rd && hit(i_sfr, CRC_PAGE_CTRL)) begin
      rdata_d = ctrl_q;
      rvalid_d = 1'b1;
    end else if (i_sfr.rd && hit(i_sfr, CRC_PAGE_CFG)) begin
      rdata_d = cfg_q & CRC_CFG_RD_MASK;
      rvalid_d = 1'b1;
    end
  end

  // R12 reset to zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= CRC_CTRL_RESET;
      cfg_q <= CRC_CFG_RESET;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      o_rdata <= rdata_d;
      o_rvalid <= rvalid_d;
    end
  end

  // ****************************************************************
  // Drive computation
  // ****************************************************************
  logic trim_wave;
  logic [5:0] count;
  logic [3:0] step;
  logic [9:0] level_d;
  crc_drive_s drive_d;

  // Builds the trim wave, the drive word and the commanded magnitude in microamps.
  always_comb begin
    trim_wave = 1'b0;
    // R8 channel select, reserved codes give no trim
    if (int'(cfg_q[2:0]) < CHANNELS) begin
      trim_wave = i_counter_array_output[cfg_q[2:0]];
    end
    count = ctrl_q[CRC_STEP_W-1:0];
    // R3 step size
    step = ctrl_q[CRC_MODE_BIT] ? CRC_HI_STEP : CRC_LO_STEP;
    // R1 enable on nonzero count
    drive_d.enable = (count != CRC_STEP_ZERO);
    // R2 direction bit
    drive_d.sink = ctrl_q[CRC_DIR_BIT];
    drive_d.high_mode = ctrl_q[CRC_MODE_BIT];
    drive_d.step_count = count;
    // R5 R7 trim cell gating
    drive_d.trim_cell_on = cfg_q[CRC_TRIM_EN_BIT] && trim_wave;
    // R4 R6 magnitude, trim cell weighs two LSBs
    // Widened before the sum so that 65 steps of eight do not wrap.
    level_d = (10'(count) + (drive_d.trim_cell_on ? 10'h002 : 10'h000)) * 10'(step);
  end

  // Registers the analog-facing outputs.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drive <= '0;
      o_level_ua <= 10'h000;
    end else begin
      o_drive <= drive_d;
      o_level_ua <= level_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // R1 enable check
  zero_disables_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    1'b1 |=> (o_drive.enable == ($past(ctrl_q[5:0]) != 6'h00))) // R1
    else $error("enable does not follow step count");
  // R2 direction check
  sink_follows_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.wr && hit(i_sfr, CRC_PAGE_CTRL)) |=> ##1 (o_drive.sink == $past(i_sfr.wdata[7], 2))) // R2
    else $error("direction not taken from bit 7");
  // R3 step size check
  high_mode_scale_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    1'b1 |=>
    (o_drive.high_mode == $past(ctrl_q[6]))) // R3
    else $error("step mode mismatch");
  // R4 magnitude check
  level_calc_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!o_drive.trim_cell_on) |-> (o_level_ua ==
    10'(o_drive.step_count * (o_drive.high_mode ? 8 : 1)))) // R4
    else $error("output level wrong");
  // R5 R7 trim gating check
  trim_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !$past(cfg_q[7]) |-> !o_drive.trim_cell_on) // R7
    else $error("trim cell on while trim disabled");
  // R6 trim equivalence check
  trim_equiv_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_drive.trim_cell_on && o_drive.step_count[1:0] == 2'b00) |->
    (o_level_ua == 10'((o_drive.step_count | 6'h02) * (o_drive.high_mode ? 8 : 1)))) // R6
    else $error("full duty trim not equal to 10b");
  // R10 unused bits check
  cfg_unused_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cfg_q[6:3] == 4'h0) // R10
    else $error("unused configuration bits set");
  // R11 read page check
  read_page_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.rd && hit(i_sfr, CRC_PAGE_CFG)) |=> (o_rvalid && o_rdata == $past(cfg_q))) // R11
    else $error("configuration read wrong");

  // ****************************************************************
  // Register access and drive checks
  // ****************************************************************
  // R11 control write lands
  ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.wr && hit(i_sfr, CRC_PAGE_CTRL)) |=>
    (ctrl_q == $past(i_sfr.wdata))) // R11
    else $error("control write lost");
  // R10 configuration write keeps used bits
  cfg_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.wr && hit(i_sfr, CRC_PAGE_CFG)) |=>
    (cfg_q[7] == $past(i_sfr.wdata[7]) && cfg_q[2:0] == $past(i_sfr.wdata[2:0]))) // R10
    else $error("configuration write lost");
  // R11 other pages ignored
  stray_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.wr && !hit(i_sfr, CRC_PAGE_CTRL) && !hit(i_sfr, CRC_PAGE_CFG)) |=>
    ($stable(ctrl_q) && $stable(cfg_q))) // R11
    else $error("write outside the register pages took effect");
  // R11 control read data
  ctrl_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sfr.rd && hit(i_sfr, CRC_PAGE_CTRL)) |=>
    (o_rvalid && o_rdata == $past(ctrl_q))) // R11
    else $error("control read wrong");
  // R11 no answer off the map
  stray_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_sfr.rd && (hit(i_sfr, CRC_PAGE_CTRL) || hit(i_sfr, CRC_PAGE_CFG))) |=>
    (!o_rvalid && o_rdata == 8'h00)) // R11
    else $error("read answered without a register hit");
  // R4 count passes through
  count_follows_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    1'b1 |=>
    (o_drive.step_count == $past(ctrl_q[5:0]))) // R4
    else $error("step count not taken from the control register");
  // R8 code 100 picks channel four
  source_four_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cfg_q[7] && cfg_q[2:0] == 3'h4) |=>
    (o_drive.trim_cell_on == $past(i_counter_array_output[4]))) // R8
    else $error("channel four not routed to the trim cell");
  // R8 reserved codes silent
  reserved_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cfg_q[2:0] == 3'h6 || cfg_q[2:0] == 3'h7) |=>
    !o_drive.trim_cell_on) // R8
    else $error("reserved select code drives the trim cell");
  // R5 trim cell weight
  trim_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_drive.trim_cell_on |->
    (o_level_ua == 10'((o_drive.step_count + 2) * (o_drive.high_mode ? 8 : 1)))) // R5
    else $error("trim cell does not add two steps");
  // R1 all zero control idles
  idle_drive_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ctrl_q == 8'h00 && !cfg_q[7]) |=>
    (o_drive == '0 && o_level_ua == 10'h000)) // R1
    else $error("reference not idle with zero control");
  // R12 state clear after reset
  reset_clear_a: assert property (@(posedge i_clk)
    $rose(i_resetn) |->
    (ctrl_q == 8'h00 && cfg_q == 8'h00 && o_drive == '0)) // R12
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

/* File: crc_pkg.sv */
`default_nettype none
package crc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CRC_SFR_ADDR = 8'hB9;
  localparam logic [3:0] CRC_PAGE_CTRL = 4'h0;
  localparam logic [3:0] CRC_PAGE_CFG = 4'hF;
  localparam logic [7:0] CRC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CRC_CFG_RESET = 8'h00;
  localparam int CRC_DIR_BIT = 7;
  localparam int CRC_MODE_BIT = 6;
  localparam int CRC_TRIM_EN_BIT = 7;
  localparam int CRC_STEP_W = 6;
  localparam logic [7:0] CRC_CFG_RD_MASK = 8'h87;
  localparam logic [5:0] CRC_STEP_ZERO = 6'h00;
  localparam logic [3:0] CRC_HI_STEP = 4'h8;
  localparam logic [3:0] CRC_LO_STEP = 4'h1;
  localparam int CRC_CHANNELS = 6;

  // Bus write and read port of the special function register space.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crc_sfr_s;

  // Analog drive settings handed to the current cell.
  typedef struct packed {
    logic enable;
    logic sink;
    logic high_mode;
    logic [5:0] step_count;
    logic trim_cell_on;
  } crc_drive_s;
endpackage
`default_nettype wire

/* File: crc_load_model.sv */
`default_nettype none
// Load on the current pin: sourced current is positive, sunk current negative.
module crc_load_model
  import crc_pkg::*;
(
  input wire crc_drive_s i_drive,
  input wire logic [9:0] i_level_ua,
  output logic signed [10:0] o_current_ua
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_current_ua = !i_drive.enable ? 11'sh000 :
    i_drive.sink ? -$signed({1'b0, i_level_ua}) : $signed({1'b0, i_level_ua});
endmodule
`default_nettype wire

/* File: crc_current_ref_test.sv */
`default_nettype none
module crc_current_ref_test
  import crc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  crc_sfr_s sfr = '0;
  logic [5:0] wave = 6'h00;
  logic [7:0] rdata;
  logic rvalid;
  crc_drive_s drive;
  logic [9:0] level;
  logic signed [10:0] cur;
  logic [7:0] ctrl;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  // Clock of 40 ns period.
  always #20 i_clk = ~i_clk;
  crc_current_ref #(.CHANNELS(CRC_CHANNELS)) crc_current_ref_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_sfr(sfr), .i_counter_array_output(wave), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_drive(drive), .o_level_ua(level));
  crc_load_model crc_load_model_inst (.i_drive(drive), .i_level_ua(level), .o_current_ua(cur));
  task automatic complete_run;
    $display("errors %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // A write strobe lasts one cycle; outputs settle two edges after it is taken.
  task automatic sfr_wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
    @(posedge i_clk);
    sfr.wr <= 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic sfr_rd(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] e,
    input logic hit);
    @(posedge i_clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
    @(posedge i_clk);
    sfr.rd <= 1'b0;
    @(negedge i_clk);
    cmp("rvalid", {10'h000, hit}, {10'h000, rvalid});
    if (hit) cmp("rdata", {3'h0, e}, {3'h0, rdata});
    else cmp("rdata", 11'h000, {3'h0, rdata});
  endtask
  // Expected drive, magnitude and load current from the control value and trim state.
  task automatic check(input logic t);
    logic [9:0] lv;
    logic [10:0] c;
    lv = ({4'h0, ctrl[5:0]} + {7'h00, t, 1'b0}) * (ctrl[6] ? 10'h008 : 10'h001);
    c = (ctrl[5:0] == 6'h00) ? 11'h000 : ctrl[7] ? -{1'b0, lv} : {1'b0, lv};
    cmp("drive", {1'b0, ctrl[5:0] != 6'h00, ctrl[7], ctrl[6], ctrl[5:0], t}, {1'b0, drive});
    cmp("level", {1'b0, lv}, {1'b0, level});
    cmp("current", c, cur);
  endtask
  task automatic set_ctrl(input logic [7:0] d);
    ctrl = d;
    sfr_wr(CRC_PAGE_CTRL, CRC_SFR_ADDR, d);
  endtask
  // Cycle ceiling cuts a hang short.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  // Main sequence of register accesses and trim waveforms.
  initial begin
    ctrl = 8'h00;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    check(1'b0);
    sfr_rd(CRC_PAGE_CTRL, CRC_SFR_ADDR, 8'h00, 1'b1);
    sfr_rd(CRC_PAGE_CFG, CRC_SFR_ADDR, 8'h00, 1'b1);
    set_ctrl(8'h45);
    check(1'b0);
    set_ctrl(8'hBF);
    check(1'b0);
    set_ctrl(8'h85);
    check(1'b0);
    set_ctrl(8'h00);
    check(1'b0);
    sfr_wr(4'h1, CRC_SFR_ADDR, 8'h3F);
    sfr_wr(CRC_PAGE_CTRL, 8'hB8, 8'h3F);
    check(1'b0);
    sfr_rd(4'h1, CRC_SFR_ADDR, 8'h00, 1'b0);
    set_ctrl(8'h44);
    for (int ch = 0; ch < CRC_CHANNELS; ch++) begin
      sfr_wr(CRC_PAGE_CFG, CRC_SFR_ADDR, 8'hF8 | ch[7:0]);
      sfr_rd(CRC_PAGE_CFG, CRC_SFR_ADDR, 8'h80 | ch[7:0], 1'b1);
      @(posedge i_clk);
      wave <= ~(6'h01 << ch);
      repeat (3) @(negedge i_clk);
      check(1'b0);
      @(posedge i_clk);
      wave <= 6'h01 << ch;
      repeat (3) @(negedge i_clk);
      check(1'b1);
    end
    sfr_wr(CRC_PAGE_CFG, CRC_SFR_ADDR, 8'h05);
    check(1'b0);
    // Reset in mid-run must clear both registers and the drive.
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    ctrl = 8'h00;
    @(negedge i_clk);
    check(1'b0);
    sfr_rd(CRC_PAGE_CTRL, CRC_SFR_ADDR, 8'h00, 1'b1);
    sfr_rd(CRC_PAGE_CFG, CRC_SFR_ADDR, 8'h00, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
